//--- fuc_regs.svh
// fuc_regs.svh: constants of the feature unlock command link and of the host register map
// assumes inclusion by the two end modules, the link checker and the bench
`ifndef FUC_REGS_SVH
`define FUC_REGS_SVH

// ----------------------------------------------------------------
// command codes, key and counts
// ----------------------------------------------------------------
`define FUC_CODE_SELECT    16'hffff
`define FUC_CODE_VIRTUAL   16'h1840
`define FUC_KEY0           16'h41ac
`define FUC_KEY1           16'hbe53
`define FUC_SELECT_COUNT   16'h0003
`define FUC_VIRTUAL_COUNT  16'h0002
`define FUC_UNIT_MAX       16'h005f
`define FUC_FEAT_W         5
`define FUC_AXES           4

// ----------------------------------------------------------------
// feature enable bit positions
// ----------------------------------------------------------------
`define FUC_FEAT_TRAVERSE  0
`define FUC_FEAT_MEMLINK   1
`define FUC_FEAT_MRESET    2
`define FUC_FEAT_FASTOUT   3
`define FUC_FEAT_SYNC      4

// ----------------------------------------------------------------
// program path codes
// ----------------------------------------------------------------
`define FUC_LINEAR_INTERP_CODE 8'h01
`define FUC_INDIRECT_REG       8'h1f
`define FUC_SYNC_GEAR          16'h0001
`define FUC_SYNC_CAM           16'h0002
`define FUC_SYNC_CANCEL        16'h0003
`define FUC_SYNC_LATCH         16'h0004

// ----------------------------------------------------------------
// timing: outstanding transfer window after each accepted transfer
// ----------------------------------------------------------------
`define FUC_XFER_NS        64
`define FUC_CLK_MHZ        125
`define FUC_XFER_CYC       ((`FUC_XFER_NS * `FUC_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// host register map (byte offsets) and status fields
// ----------------------------------------------------------------
`define FUC_OFF_CTRL       8'h00
`define FUC_OFF_CODE       8'h04
`define FUC_OFF_SRC0       8'h08
`define FUC_OFF_SRC1       8'h0c
`define FUC_OFF_SRC2       8'h10
`define FUC_OFF_UNIT       8'h14
`define FUC_OFF_COUNT      8'h18
`define FUC_OFF_STATUS     8'h1c
`define FUC_CTRL_GO        0
`define FUC_STAT_PEND      0
`define FUC_STAT_DONE      1
`define FUC_STAT_EQ        2
`define FUC_STAT_RES_LSB   4
`define FUC_AXI_AW         8
`define FUC_RESP_OKAY      2'b00
`define FUC_RESP_SLVERR    2'b10

`endif

//--- fuc_pkg.sv
// fuc_pkg.sv: types shared by the link interface and both ends
// assumes fuc_regs.svh on the include path
package fuc_pkg;
   // answer of the device to one transfer
   typedef enum logic [1:0] {
      FUC_RES_OK    = 2'b00,
      FUC_RES_BUSY  = 2'b01,
      FUC_RES_ABORT = 2'b10,
      FUC_RES_FMT   = 2'b11
   } fuc_res_t;

   // device sequencer states
   typedef enum logic [2:0] {
      FUC_ST_IDLE = 3'b001,
      FUC_ST_EVAL = 3'b010,
      FUC_ST_RESP = 3'b100
   } fuc_state_t;

   typedef logic [15:0] fuc_word_t;
   typedef logic [31:0] fuc_pos_t;
endpackage

//--- fuc_link_if.sv
// fuc_link_if.sv: transfer link between host end and device end
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface fuc_link_if;
   import fuc_pkg::*;
   logic       req;       // host holds until resp_valid
   fuc_word_t  ctrl_code;
   fuc_word_t  src0;
   fuc_word_t  src1;
   fuc_word_t  src2;
   fuc_word_t  dst_unit;
   fuc_word_t  dst_count;
   logic       resp_valid; // one-cycle answer
   fuc_res_t   resp;

   modport dev  (input req, ctrl_code, src0, src1, src2, dst_unit, dst_count, output resp_valid, resp);
   modport host (output req, ctrl_code, src0, src1, src2, dst_unit, dst_count, input resp_valid, resp);
endinterface

//--- fuc_host.sv
// fuc_host.sv: host end, takes orders from software over AXI4-Lite and issues transfers
// assumes an AXI4-Lite master on CLOCK and the device end on the link
`timescale 1ns/1ns
`include "fuc_regs.svh"
module fuc_host (
   // clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RESET,
   // link
   fuc_link_if.host               LINK,
   // axi4-lite slave
   input  wire logic [7:0]        S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output      logic              S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output      logic              S_AXI_WREADY,
   output      logic [1:0]        S_AXI_BRESP,
   output      logic              S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [7:0]        S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output      logic              S_AXI_ARREADY,
   output      logic [31:0]       S_AXI_RDATA,
   output      logic [1:0]        S_AXI_RRESP,
   output      logic              S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY
);
   import fuc_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   fuc_word_t  word_reg [0:5];     // code, src0..2, unit, count
   logic       aw_hold_reg;
   logic       w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [15:0] wdata_reg;
   logic [1:0] wstrb_reg;
   logic       pend_reg;
   logic       done_reg;
   fuc_res_t   res_reg;
   logic       do_write;
   logic [2:0] widx;

   // byte-lane merge of a 16-bit register
   function automatic fuc_word_t merge16(input fuc_word_t old, input fuc_word_t d, input logic [1:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // write channel: address and data taken in either order
   // ----------------------------------------------------------------
   assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_hold_reg && !S_AXI_BVALID;
   assign do_write      = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
   assign widx          = awaddr_reg[4:2];

   // capture of address and data
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 16'h0000;
         wstrb_reg   <= 2'b00;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= S_AXI_AWADDR;
         end else if (do_write) begin
            aw_hold_reg <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= S_AXI_WDATA[15:0];
            wstrb_reg  <= S_AXI_WSTRB[1:0];
         end else if (do_write) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // write response; upper address space is unmapped
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `FUC_RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= (awaddr_reg[7:5] != 3'b000) ? `FUC_RESP_SLVERR : `FUC_RESP_OKAY;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // payload words are frozen while a transfer is pending so the link payload stays stable
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         for (int i = 0; i < 6; i++) begin
            word_reg[i] <= 16'h0000;
         end
      end else if (do_write && !pend_reg && awaddr_reg[7:5] == 3'b000 && widx >= 3'd1 && widx <= 3'd6) begin
         word_reg[widx - 3'd1] <= merge16(word_reg[widx - 3'd1], wdata_reg, wstrb_reg);
      end
   end

   // ----------------------------------------------------------------
   // transfer sequencing
   // ----------------------------------------------------------------
   // go starts one transfer; a go while pending is ignored
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         pend_reg <= 1'b0;
         done_reg <= 1'b0;
         res_reg  <= FUC_RES_OK;
      end else if (pend_reg) begin
         if (LINK.resp_valid) begin
            pend_reg <= 1'b0;
            done_reg <= 1'b1;
            res_reg  <= LINK.resp;
         end
      end else if (do_write && awaddr_reg == `FUC_OFF_CTRL && wstrb_reg[0] && wdata_reg[`FUC_CTRL_GO]) begin
         pend_reg <= 1'b1;
         done_reg <= 1'b0;
      end
   end

   // link drive from registers
   assign LINK.req       = pend_reg;
   assign LINK.ctrl_code = word_reg[0];
   assign LINK.src0      = word_reg[1];
   assign LINK.src1      = word_reg[2];
   assign LINK.src2      = word_reg[3];
   assign LINK.dst_unit  = word_reg[4];
   assign LINK.dst_count = word_reg[5];

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // one read at a time, data registered
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= `FUC_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= `FUC_RESP_OKAY;
         S_AXI_RDATA  <= 32'h00000000;
         if (S_AXI_ARADDR[7:5] != 3'b000) begin
            S_AXI_RRESP <= `FUC_RESP_SLVERR;
         end else if (S_AXI_ARADDR[4:2] == 3'd7) begin
            S_AXI_RDATA[`FUC_STAT_PEND] <= pend_reg;
            S_AXI_RDATA[`FUC_STAT_DONE] <= done_reg;
            S_AXI_RDATA[`FUC_STAT_EQ]   <= done_reg && (res_reg == FUC_RES_OK); // equality flag
            S_AXI_RDATA[`FUC_STAT_RES_LSB +: 2] <= res_reg;
         end else if (S_AXI_ARADDR[4:2] != 3'd0) begin
            S_AXI_RDATA[15:0] <= word_reg[S_AXI_ARADDR[4:2] - 3'd1];
         end
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule

//--- fuc_dev.sv
// fuc_dev.sv: device end, checks keyed feature selection and virtual axis transfers
// assumes the host end on the link, pendant mode lines from outside the clock domain
//
// Operation
// - all-ones code selects customized feature command
// - two key words must match, else abort
// - low five enable bits switch features on
// - bits: traverse, memlink, mreset, fastout, sync
// - host keeps reserved enable bits zero
// - unit number must be zero to ninety-five
// - word count must be three, else abort
// - valid command enables features, equality flag set
// - outstanding previous transfer answers busy
// - pendant enabled or occupy mode answers busy
// - second selection refused as format error
// - feature enables zero after reset
// - host should select features first after reset
// - new enables apply at once, mid motion
// - separate code sets virtual axes, host only
// - any of four axes may be virtual
// - config bits zero to three map X,Y,Z,U
// - virtual axis feedback equals position command
// - indirect linear move, table value 1 gear
// - table values 2 cam, 3 cancel, 4 latch
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "fuc_regs.svh"
module fuc_dev (
   // clock and reset
   input  wire logic                       CLOCK,
   input  wire logic                       RESET,
   // link
   fuc_link_if.dev                         LINK,
   // identity and pendant state
   input  wire logic [6:0]                 UNIT_NUMBER,
   input  wire logic                       PENDANT_ENABLED,
   input  wire logic                       PENDANT_OCCUPY,
   // feature enables
   output      logic [`FUC_FEAT_W-1:0]     FEATURE_EN,
   output      logic [`FUC_AXES-1:0]       VIRTUAL_AXES,
   // axis position paths
   input  wire fuc_pkg::fuc_pos_t          CMD_POS [`FUC_AXES],
   input  wire fuc_pkg::fuc_pos_t          ENC_POS [`FUC_AXES],
   output      fuc_pkg::fuc_pos_t          FB_POS [`FUC_AXES],
   // program path
   input  wire logic                       PROG_VALID,
   input  wire logic [7:0]                 PROG_OPCODE,
   input  wire logic [7:0]                 PROG_OPERAND_REG,
   input  wire fuc_pkg::fuc_word_t         PROG_TABLE0,
   output      logic                       SYNC_GEAR,
   output      logic                       SYNC_CAM,
   output      logic                       SYNC_CANCEL,
   output      logic                       SYNC_LATCH,
   output      logic                       SYNC_REJECT
);
   import fuc_pkg::*;

   localparam logic [3:0] XFER_CYC = 4'(`FUC_XFER_CYC);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fuc_state_t  state_reg;
   fuc_state_t  state_next;
   fuc_res_t    res_reg;
   fuc_res_t    res_next;
   logic [1:0]  pen_en_sync;
   logic [1:0]  pen_oc_sync;
   logic        pendant_busy;
   logic [3:0]  xfer_cnt_reg;
   logic        once_reg;
   logic [`FUC_FEAT_W-1:0] feat_reg;
   logic [`FUC_AXES-1:0]   virt_reg;
   logic        is_select;
   logic        is_virtual;
   logic        prog_hit;

   // ----------------------------------------------------------------
   // pendant synchronisers
   // ----------------------------------------------------------------
   // pendant lines come from another domain, two flops before use
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         pen_en_sync <= 2'b00;
         pen_oc_sync <= 2'b00;
      end else begin
         pen_en_sync <= {pen_en_sync[0], PENDANT_ENABLED};
         pen_oc_sync <= {pen_oc_sync[0], PENDANT_OCCUPY};
      end
   end

   assign pendant_busy = pen_en_sync[1] || pen_oc_sync[1];

   // ----------------------------------------------------------------
   // transfer check
   // ----------------------------------------------------------------
   assign is_select  = (LINK.ctrl_code == `FUC_CODE_SELECT);
   assign is_virtual = (LINK.ctrl_code == `FUC_CODE_VIRTUAL);

   // answer priority: busy, addressing, count, key, repeat
   always_comb begin
      res_next = FUC_RES_OK;
      if (xfer_cnt_reg != 4'h0) begin
         res_next = FUC_RES_BUSY;
      end else if (pendant_busy) begin
         res_next = FUC_RES_BUSY;
      end else if (LINK.dst_unit > `FUC_UNIT_MAX || LINK.dst_unit[6:0] != UNIT_NUMBER) begin
         res_next = FUC_RES_ABORT;
      end else if (is_select) begin
         if (LINK.dst_count != `FUC_SELECT_COUNT) begin
            res_next = FUC_RES_ABORT;
         end else if (LINK.src0 != `FUC_KEY0 || LINK.src1 != `FUC_KEY1) begin
            res_next = FUC_RES_ABORT;
         end else if (once_reg) begin
            res_next = FUC_RES_FMT;
         end
      end else if (is_virtual) begin
         if (LINK.dst_count != `FUC_VIRTUAL_COUNT || LINK.src1 != 16'h0000) begin
            res_next = FUC_RES_ABORT;
         end
      end else begin
         res_next = FUC_RES_ABORT;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // take, evaluate, answer; the host drops req at the answer edge
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FUC_ST_IDLE: begin
            if (LINK.req) begin
               state_next = FUC_ST_EVAL;
            end
         end
         FUC_ST_EVAL: begin
            state_next = FUC_ST_RESP;
         end
         FUC_ST_RESP: begin
            state_next = FUC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_reg <= FUC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // answer code held from evaluation through the answer cycle
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         res_reg <= FUC_RES_OK;
      end else if (state_reg == FUC_ST_EVAL) begin
         res_reg <= res_next;
      end
   end

   assign LINK.resp_valid = (state_reg == FUC_ST_RESP);
   assign LINK.resp       = res_reg;

   // outstanding window opens on every accepted transfer; a busy answer does not extend it
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         xfer_cnt_reg <= 4'h0;
      end else if (state_reg == FUC_ST_EVAL && res_next == FUC_RES_OK) begin
         xfer_cnt_reg <= XFER_CYC;
      end else if (xfer_cnt_reg != 4'h0) begin
         xfer_cnt_reg <= xfer_cnt_reg - 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // enable latches
   // ----------------------------------------------------------------
   // only a good selection writes; reserved upper bits are dropped
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         feat_reg <= '0;
         once_reg <= 1'b0;
      end else if (state_reg == FUC_ST_EVAL && is_select && res_next == FUC_RES_OK) begin
         feat_reg <= LINK.src2[`FUC_FEAT_W-1:0];
         once_reg <= 1'b1;
      end
   end

   // virtual axis set may be repeated; the program path cannot reach it
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         virt_reg <= '0;
      end else if (state_reg == FUC_ST_EVAL && is_virtual && res_next == FUC_RES_OK) begin
         virt_reg <= LINK.src0[`FUC_AXES-1:0];
      end
   end

   // enables drive the feature logic directly, no wait for motion to end
   assign FEATURE_EN   = feat_reg;
   assign VIRTUAL_AXES = virt_reg;

   // ----------------------------------------------------------------
   // axis feedback
   // ----------------------------------------------------------------
   // a virtual axis reads back its own command, so following error is zero
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         for (int a = 0; a < `FUC_AXES; a++) begin
            FB_POS[a] <= 32'h00000000;
         end
      end else begin
         for (int a = 0; a < `FUC_AXES; a++) begin
            FB_POS[a] <= virt_reg[a] ? CMD_POS[a] : ENC_POS[a];
         end
      end
   end

   // ----------------------------------------------------------------
   // program path selection
   // ----------------------------------------------------------------
   assign prog_hit = PROG_VALID && PROG_OPCODE == `FUC_LINEAR_INTERP_CODE
                     && PROG_OPERAND_REG == `FUC_INDIRECT_REG;

   // one-cycle pulses; group disabled or unknown table code is rejected
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         SYNC_GEAR   <= 1'b0;
         SYNC_CAM    <= 1'b0;
         SYNC_CANCEL <= 1'b0;
         SYNC_LATCH  <= 1'b0;
         SYNC_REJECT <= 1'b0;
      end else begin
         SYNC_GEAR   <= 1'b0;
         SYNC_CAM    <= 1'b0;
         SYNC_CANCEL <= 1'b0;
         SYNC_LATCH  <= 1'b0;
         SYNC_REJECT <= 1'b0;
         if (prog_hit) begin
            if (!feat_reg[`FUC_FEAT_SYNC]) begin
               SYNC_REJECT <= 1'b1;
            end else if (PROG_TABLE0 == `FUC_SYNC_GEAR) begin
               SYNC_GEAR <= 1'b1;
            end else if (PROG_TABLE0 == `FUC_SYNC_CAM) begin
               SYNC_CAM <= 1'b1;
            end else if (PROG_TABLE0 == `FUC_SYNC_CANCEL) begin
               SYNC_CANCEL <= 1'b1;
            end else if (PROG_TABLE0 == `FUC_SYNC_LATCH) begin
               SYNC_LATCH <= 1'b1;
            end else begin
               SYNC_REJECT <= 1'b1;
            end
         end
      end
   end
endmodule

//--- fuc_link_checker.sv
// fuc_link_checker.sv: link assertions for the feature unlock command
// assumes instantiation beside fuc_link_if, one clock, sync reset
`timescale 1ns/1ns
`include "fuc_regs.svh"
module fuc_link_checker (
   // clock and reset
   input wire logic              CLOCK,
   input wire logic              RESET,
   // link
   input wire logic              req,
   input wire fuc_pkg::fuc_word_t ctrl_code,
   input wire fuc_pkg::fuc_word_t src0,
   input wire fuc_pkg::fuc_word_t src1,
   input wire fuc_pkg::fuc_word_t dst_unit,
   input wire fuc_pkg::fuc_word_t dst_count,
   input wire logic              resp_valid,
   input wire fuc_pkg::fuc_res_t  resp
);
   import fuc_pkg::*;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   logic sel_ok_reg;
   // one accepted selection locks out every later one until reset
   always_ff @(posedge CLOCK) begin
      if (RESET)
         sel_ok_reg <= 1'b0;
      else if (resp_valid && ctrl_code == `FUC_CODE_SELECT && resp == FUC_RES_OK)
         sel_ok_reg <= 1'b1;
   end
   // a take and its answer two edges later
   sequence s_take;
      $rose(req);
   endsequence
   sequence s_answer;
      (req && !resp_valid)[*2] ##1 (req && resp_valid);
   endsequence
   // an answer to a selection transfer
   logic sel_ans;
   assign sel_ans = resp_valid && ctrl_code == `FUC_CODE_SELECT;
   a_answer_time: assert property (s_take |-> s_answer) else $error("late answer");
   a_answer_pulse: assert property (resp_valid |=> !resp_valid) else $error("long answer");
   a_code_known: assert property (resp_valid && ctrl_code != `FUC_CODE_SELECT && ctrl_code != `FUC_CODE_VIRTUAL
      |-> resp != FUC_RES_OK) else $error("unknown code ok");
   a_key_check: assert property (sel_ans && (src0 != `FUC_KEY0 || src1 != `FUC_KEY1) |-> resp != FUC_RES_OK)
      else $error("bad key ok");
   a_unit_range: assert property (resp_valid && dst_unit > `FUC_UNIT_MAX |-> resp != FUC_RES_OK)
      else $error("bad unit ok");
   a_sel_count: assert property (sel_ans && dst_count != `FUC_SELECT_COUNT |-> resp != FUC_RES_OK)
      else $error("bad count ok");
   a_virt_count: assert property (resp_valid && ctrl_code == `FUC_CODE_VIRTUAL && dst_count != `FUC_VIRTUAL_COUNT
      |-> resp != FUC_RES_OK) else $error("bad virtual count ok");
   a_sel_once: assert property (sel_ans && sel_ok_reg |-> resp != FUC_RES_OK) else $error("second select ok");
endmodule

//--- feature_unlock_command_bench.sv
// feature_unlock_command_bench.sv: both ends on one link, driven over AXI4-Lite
// assumes fuc_pkg, fuc_link_if, fuc_host, fuc_dev and the checker compiled first
`timescale 1ns/1ns
`include "fuc_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, g, e); end end
module feature_unlock_command_bench;
   import fuc_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clock = 1'b0, reset = 1'b1;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rr;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic        pend_en = 0, pend_occ = 0, pvalid = 0, gear, cam, cancel, latch, reject;
   logic [15:0] ptab = 16'h0;
   logic [7:0]  pop = 8'h01;
   logic [4:0]  feat;
   logic [3:0]  virt;
   fuc_pos_t    cmdp [4] = '{32'h100, 32'h101, 32'h102, 32'h103};
   fuc_pos_t    encp [4] = '{32'h200, 32'h201, 32'h202, 32'h203};
   fuc_pos_t    fbp [4];
   int          errors = 0, n_tests = 0, cyc = 0;
   fuc_link_if link ();
   fuc_host i_fuc_host (.CLOCK(clock), .RESET(reset), .LINK(link), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   fuc_dev i_fuc_dev (.CLOCK(clock), .RESET(reset), .LINK(link), .UNIT_NUMBER(7'd5), .PENDANT_ENABLED(pend_en),
      .PENDANT_OCCUPY(pend_occ), .FEATURE_EN(feat), .VIRTUAL_AXES(virt), .CMD_POS(cmdp), .ENC_POS(encp),
      .FB_POS(fbp), .PROG_VALID(pvalid), .PROG_OPCODE(pop), .PROG_OPERAND_REG(8'h1f), .PROG_TABLE0(ptab),
      .SYNC_GEAR(gear), .SYNC_CAM(cam), .SYNC_CANCEL(cancel), .SYNC_LATCH(latch), .SYNC_REJECT(reject));
   fuc_link_checker i_fuc_link_checker (.CLOCK(clock), .RESET(reset), .req(link.req), .ctrl_code(link.ctrl_code),
      .src0(link.src0), .src1(link.src1), .dst_unit(link.dst_unit), .dst_count(link.dst_count),
      .resp_valid(link.resp_valid), .resp(link.resp));
   // ----------------------------------------------------------------
   // clock, hang guard and bus tasks
   // ----------------------------------------------------------------
   initial forever #4 clock = ~clock;
   // the whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         end_of_test();
      end
   end
   // handshakes are sampled at the falling edge so no race with the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
         @(negedge clock);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         @(posedge clock);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
   endtask
   task automatic rd_t(input logic [7:0] a);
      logic ar_t, r_t;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
         @(negedge clock);
         ar_t = arvalid && arready;
         r_t = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge clock);
         if (ar_t) arvalid <= 1'b0;
      end
   endtask
   // start, poll done and check the result code
   task automatic go(input fuc_res_t r);
      wr(8'h00, 32'h1);
      rd = 32'h0;
      for (int k = 0; k < 50 && rd[1] !== 1'b1; k++) rd_t(8'h1c);
      `CHK(rd[5:4], r)
      `CHK(rd[2], r == FUC_RES_OK)
   endtask
   // load the six link words, then start
   task automatic cmd(input fuc_word_t c, s0, s1, s2, u, n, input fuc_res_t r);
      fuc_word_t w [6];
      w = '{c, s0, s1, s2, u, n};
      for (int k = 0; k < 6; k++) wr(8'h04 + 8'(4 * k), {16'h0, w[k]});
      go(r);
   endtask
   task end_of_test;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      `CHK({feat, virt}, 9'h0)
      pend_en <= 1'b1;
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h001f, 16'h5, 16'h3, FUC_RES_BUSY);
      pend_en <= 1'b0;
      pend_occ <= 1'b1;
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h001f, 16'h5, 16'h3, FUC_RES_BUSY);
      pend_occ <= 1'b0;
      repeat (4) @(posedge clock);
      cmd(16'hffff, 16'h41ad, 16'hbe53, 16'h001f, 16'h5, 16'h3, FUC_RES_ABORT);
      cmd(16'hffff, 16'h41ac, 16'hbe52, 16'h001f, 16'h5, 16'h3, FUC_RES_ABORT);
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h001f, 16'h5, 16'h2, FUC_RES_ABORT);
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h001f, 16'h60, 16'h3, FUC_RES_ABORT);
      cmd(16'h1234, 16'h41ac, 16'hbe53, 16'h001f, 16'h5, 16'h3, FUC_RES_ABORT);
      `CHK(feat, 5'h00)
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h0015, 16'h5, 16'h3, FUC_RES_OK);
      `CHK(feat, 5'h15)
      cmd(16'hffff, 16'h41ac, 16'hbe53, 16'h000a, 16'h5, 16'h3, FUC_RES_FMT);
      `CHK(feat, 5'h15)
      cmd(16'h1840, 16'h000a, 16'h0, 16'h0, 16'h5, 16'h3, FUC_RES_ABORT);
      cmd(16'h1840, 16'h000a, 16'h0, 16'h0, 16'h5, 16'h2, FUC_RES_OK);
      // a start right after an accepted transfer is still busy
      go(FUC_RES_BUSY);
      `CHK(virt, 4'ha)
      for (int k = 0; k < 4; k++) `CHK(fbp[k], k[0] ? cmdp[k] : encp[k])
      for (int k = 1; k < 7; k++) begin
         ptab <= 16'(k);
         pop <= (k == 6) ? 8'h00 : 8'h01;
         pvalid <= 1'b1;
         @(posedge clock);
         pvalid <= 1'b0;
         @(negedge clock);
         `CHK({gear, cam, cancel, latch, reject}, 5'h10 >> (k - 1))
         @(posedge clock);
      end
      // an unmapped word answers with a slave error and zero data
      rd_t(8'h40);
      `CHK({rr, rd}, {2'b10, 32'h0})
      end_of_test();
   end
endmodule
